// file: verif/ecrm_far.sv
// Far-side model: clock and data sources and the hardware RF pin
`timescale 1ns/1ns
module ecrm_far (
    input wire logic clk_on,
    input wire logic tr_on,
    input wire logic pin_lvl,
    output logic [1:0] ext_clk_present,
    output logic [1:0] data_transitions,
    output logic rf_onoff_pin
);
    // Both channels see the same sources, so one loss reaches both channels
    assign ext_clk_present = {2{clk_on}};
    assign data_transitions = {2{tr_on}};
    assign rf_onoff_pin = pin_lvl;
endmodule

// file: verif/ext_ctrl_and_rf_mute_test.sv
// Self-checking bench for the external control and RF mute block
`timescale 1ns/1ns
module ext_ctrl_and_rf_mute_test;
    localparam logic [1:0] OK = 2'h0;
    localparam logic [1:0] SE = 2'h2;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0000_0000, rd_d, seed = 32'h31ac_bb01, r;
    logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
    logic awr, wr_r, bv, arr, rv, pin;
    logic [1:0] bresp, rresp, xo, rf, co, ecp, dtr;
    logic clk_on = 1'b1, tr_on = 1'b1, pin_lvl = 1'b1;
    int error_cnt = 0, total_checks = 0;
    always #2 aclk = ~aclk;
    ecrm_top #(.PRES_CYCLES(8)) dut_u (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(bresp),
        .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd_d), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rr), .ext_clk_present(ecp), .data_transitions(dtr),
        .rf_onoff_pin(pin), .ext_ctrl_out(xo), .rf_enable_out(rf), .carrier_only_out(co));
    ecrm_far far_u (.clk_on(clk_on), .tr_on(tr_on), .pin_lvl(pin_lvl),
        .ext_clk_present(ecp), .data_transitions(dtr), .rf_onoff_pin(pin));
    function logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function logic fx(input logic [1:0] s, input logic inv, input logic ge);
        return ((s == 2'h2) ? ge : (s == 2'h1)) ^ inv;
    endfunction
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s exp %h got %h", n, e, g);
        end
    endtask
    task w(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // Master holds each channel until its own ready is seen at an edge
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
        do begin
            @(posedge aclk);
            if (awr) awv <= 1'b0;
            if (wr_r) wv <= 1'b0;
        end while (bv !== 1'b1);
        br <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, bresp});
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge aclk);
        ara <= a; arv <= 1'b1; rr <= 1'b1;
        do begin
            @(posedge aclk);
            if (arr) arv <= 1'b0;
        end while (rv !== 1'b1);
        rr <= 1'b0;
        chk("rdata", e, rd_d);
        chk("rresp", {30'h0, er}, {30'h0, rresp});
    endtask
    task end_of_test();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #200000;
        error_cnt++;
        end_of_test();
    end
    initial begin
        w(16);
        aresetn <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            wr(8'h04, {29'h0, i[1], 1'b0, i[0]}, OK);
            w(3);
            chk("xo", fx({1'b0, i[0]}, i[1], 1'b0), xo[0]);
        end
        wr(8'h08, 32'h8d3e_d780, OK);
        wr(8'h0c, 32'h0, OK);
        wr(8'h04, 32'h2, OK);
        w(3);
        chk("xo", fx(2'h2, 1'b0, 1'b1), xo[0]);
        wr(8'h08, 32'h8d3e_d781, OK);
        wr(8'h0c, 32'h0, OK);
        w(3);
        chk("xo", fx(2'h2, 1'b0, 1'b0), xo[0]);
        wr(8'h08, 32'h3985_3b00, OK);
        wr(8'h0c, 32'h1, OK);
        rd(8'h0c, 32'h1, OK);
        wr(8'h08, 32'h3985_3b01, OK);
        wr(8'h0c, 32'h1, SE);
        wr(8'h08, 32'h0beb_c1ff, OK);
        wr(8'h0c, 32'h0, SE);
        w(3);
        chk("xo", 32'h0, xo[0]);
        wr(8'h08, 32'h0beb_c200, OK);
        wr(8'h0c, 32'h0, OK);
        w(3);
        chk("xo", 32'h1, xo[0]);
        wr(8'h00, 32'h3, OK);
        wr(8'h04, 32'h1, OK);
        w(3);
        chk("xo", 32'h3, xo);
        wr(8'h68, 32'h1, OK);
        wr(8'ha8, 32'h1, OK);
        rd(8'h00, 32'h3, OK);
        rd(8'h68, 32'h1, OK);
        rd(8'h44, 32'h0, SE);
        wr(8'h44, 32'h0, SE);
        wr(8'h18, 32'h0, SE);
        repeat (6) begin
            r = xs();
            wr(8'h10, {31'h0, r[1]}, OK);
            pin_lvl <= r[0];
            w(10);
            chk("rf", {2{r[1] ? r[0] : ~r[0]}}, rf);
        end
        wr(8'h10, 32'h1, OK);
        pin_lvl <= 1'b1;
        clk_on <= 1'b0;
        w(30);
        chk("rf", 32'h0, rf);
        wr(8'h10, 32'h3, OK);
        w(3);
        chk("co", 32'h3, co);
        clk_on <= 1'b1;
        w(30);
        chk("co", 32'h0, co);
        wr(8'h10, 32'h5, OK);
        tr_on <= 1'b0;
        w(30);
        chk("rf", 32'h0, rf);
        tr_on <= 1'b1;
        w(30);
        chk("rf", 32'h3, rf);
        wr(8'h6c, 32'h1, OK);
        wr(8'h10, 32'h1, OK);
        clk_on <= 1'b0;
        w(30);
        chk("rf", 32'h1, rf);
        end_of_test();
    end
endmodule

// file: verilog/ecrm_pkg.sv
// Constants shared by the external-control and RF-mute block
package ecrm_pkg;
    // ==========================================================
    // Bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ==========================================================
    // Register offsets inside one view (low six address bits)
    localparam logic [5:0] OFF_CUR_CHAN = 6'h00;
    localparam logic [5:0] OFF_EXT_CTRL = 6'h04;
    localparam logic [5:0] OFF_THRESH_LO = 6'h08;
    localparam logic [5:0] OFF_THRESH_HI = 6'h0C;
    localparam logic [5:0] OFF_OPTIONS = 6'h10;
    localparam logic [5:0] OFF_STATUS = 6'h14;
    localparam logic [5:0] OFF_FREQ_LO = 6'h20;
    localparam logic [5:0] OFF_FREQ_HI = 6'h24;
    localparam logic [5:0] OFF_RF_SOFT = 6'h28;
    localparam logic [5:0] OFF_CLK_SRC = 6'h2C;
    // Address bits [7:6] carry the channel prefix; 0 means current channel
    localparam int PREFIX_LSB = 6;
    // ==========================================================
    // Field positions and encodings
    localparam int EXT_SET_LSB = 0;
    localparam int EXT_INV_BIT = 2;
    localparam int OPT_PIN_POL_BIT = 0;
    localparam int OPT_CARRIER_BIT = 1;
    localparam int OPT_CLK_FREE_BIT = 2;
    localparam int ST_RF_LSB = 0;
    localparam int ST_CARRIER_LSB = 2;
    localparam int ST_EXT_LSB = 4;
    localparam int ST_PRESENT_LSB = 6;
    localparam int ST_REJECT_BIT = 8;
    localparam logic [1:0] SET_LOW = 2'h0;
    localparam logic [1:0] SET_HIGH = 2'h1;
    localparam logic [1:0] SET_AUTO = 2'h2;
    localparam logic [1:0] CHAN_BOTH = 2'h3;
    localparam logic CLK_SRC_EXT = 1'h0;
    // ==========================================================
    // Reset values
    localparam logic [1:0] RST_CUR_CHAN = 2'h1;
    localparam logic [1:0] RST_SETTING = SET_LOW;
    localparam logic [32:0] RST_THRESH = 33'h0_7735_9400;
    localparam logic [32:0] RST_FREQ = 33'h0_8D3E_D780;
    localparam logic RST_RF_SOFT = 1'h0;
    localparam logic RST_PIN_POL = 1'h1;
    // ==========================================================
    // Threshold limits in Hz: 200.0 MHz and 5260.0 MHz
    localparam logic [32:0] THRESH_MIN = 33'h0_0BEB_C200;
    localparam logic [32:0] THRESH_MAX = 33'h1_3985_3B00;
    // ==========================================================
    // Presence settling time
    localparam int CLK_HZ = 250_000_000;
    localparam int PRES_DELAY_MS = 100;
    localparam int PRES_CYCLES = (CLK_HZ / 1000) * PRES_DELAY_MS;
    localparam int CNT_W = 25;
endpackage

// file: verilog/ecrm_top.sv
// External device control outputs and RF mute logic with AXI4-Lite registers
//
// Implementation choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ns
// Contract
// - Each channel keeps its own control settings; channel 3 writes both.
// - Forced-low drives control output 0, or 1 when inverted.
// - Forced-high drives control output 1, or 0 when inverted.
// - Automatic gives 1 when frequency is at or above threshold, else 0.
// - Threshold matters only in automatic setting.
// - Threshold is held in whole hertz.
// - Threshold accepted only from 200.0 MHz to 5260.0 MHz inclusive.
// - Raw level is found first, then inverted when invert bit is 1.
// - Prefixed command acts on named channels; current channel unchanged.
// - Prefix honoured only for the listed channel settings.
// - Per-channel soft RF enable, readable; 0 mutes the channel.
// - External clock, not clock-free: mute while clock is absent.
// - With auto-carrier fitted, loss gives a plain carrier instead of mute.
// - RF follows clock return automatically after about 0.1 seconds.
// - Clock-free mode watches data transitions the same way.
// - Hardware pin only vetoes RF; it never forces RF on.
// - Pin polarity 1 permits on high level, 0 permits on low level.
// - Soft enable write 1 enables, 0 disables; read returns state.
module ecrm_top #(
    parameter int PRES_CYCLES = ecrm_pkg::PRES_CYCLES,
    parameter bit CARRIER_FITTED = 1'b1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ecrm_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [ecrm_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ecrm_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [ecrm_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] ext_clk_present,
    input wire logic [1:0] data_transitions,
    input wire logic rf_onoff_pin,
    output logic [1:0] ext_ctrl_out,
    output logic [1:0] rf_enable_out,
    output logic [1:0] carrier_only_out
);
    // ==========================================================
    // State
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic aw_full;
        logic w_full;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic [1:0] cur_chan;
        logic [1:0][1:0] setting;
        logic [1:0] invert;
        logic [1:0][32:0] thresh;
        logic [31:0] thr_stage;
        logic [1:0][32:0] freq;
        logic [31:0] frq_stage;
        logic [1:0] rf_soft;
        logic [1:0] clk_src;
        logic [1:0] auto_carrier_enable;
        logic [1:0] clock_free_mode;
        logic pin_pol;
        logic thr_reject;
        logic [1:0] clk_s1;
        logic [1:0] clk_s2;
        logic [1:0] clk_s3;
        logic [1:0] clk_f;
        logic [1:0] tr_s1;
        logic [1:0] tr_s2;
        logic [1:0] tr_s3;
        logic [1:0] tr_f;
        logic pin_s1;
        logic pin_s2;
        logic pin_s3;
        logic pin_f;
        logic [1:0] present;
        logic [1:0][ecrm_pkg::CNT_W-1:0] cnt;
        logic [1:0] ext_out;
        logic [1:0] rf_out;
        logic [1:0] car_out;
    } ecrm_state_t;

    ecrm_state_t state_reg;
    ecrm_state_t state_next;
    logic pin_permit;
    logic [1:0] raw_present;
    logic [1:0] carrier_ok;

    function automatic logic [31:0] ecrm_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return res;
    endfunction

    // The pin is a veto only: it can remove permission, never grant RF
    assign pin_permit = state_reg.pin_pol ? state_reg.pin_f : !state_reg.pin_f;

    always_comb begin
        for (int c = 0; c < 2; c++) begin
            if (state_reg.clock_free_mode[c]) begin
                raw_present[c] = state_reg.tr_f[c];
            end else if (state_reg.clk_src[c] == ecrm_pkg::CLK_SRC_EXT) begin
                raw_present[c] = state_reg.clk_f[c];
            end else begin
                raw_present[c] = 1'b1;
            end
            carrier_ok[c] = CARRIER_FITTED && state_reg.auto_carrier_enable[c];
        end
    end

    // ==========================================================
    // Next state
    always_comb begin
        logic [1:0] pfx;
        logic [5:0] off;
        logic [1:0] mask;
        logic vc;
        logic [31:0] old_v;
        logic [31:0] wd;
        logic [32:0] thr_new;
        logic ok;
        logic [1:0] rpfx;
        logic [5:0] roff;
        logic rvc;
        logic rok;
        logic [31:0] rd;
        pfx = 2'h0;
        off = 6'h00;
        mask = 2'h0;
        vc = 1'b0;
        old_v = 32'h0000_0000;
        wd = 32'h0000_0000;
        thr_new = 33'h0_0000_0000;
        ok = 1'b0;
        rpfx = 2'h0;
        roff = 6'h00;
        rvc = 1'b0;
        rok = 1'b0;
        rd = 32'h0000_0000;
        state_next = state_reg;

        // Synchronisers: a change counts once stages two and three agree
        state_next.clk_s1 = ext_clk_present;
        state_next.clk_s2 = state_reg.clk_s1;
        state_next.clk_s3 = state_reg.clk_s2;
        state_next.tr_s1 = data_transitions;
        state_next.tr_s2 = state_reg.tr_s1;
        state_next.tr_s3 = state_reg.tr_s2;
        state_next.pin_s1 = rf_onoff_pin;
        state_next.pin_s2 = state_reg.pin_s1;
        state_next.pin_s3 = state_reg.pin_s2;
        for (int c = 0; c < 2; c++) begin
            if (state_reg.clk_s2[c] == state_reg.clk_s3[c]) begin
                state_next.clk_f[c] = state_reg.clk_s3[c];
            end
            if (state_reg.tr_s2[c] == state_reg.tr_s3[c]) begin
                state_next.tr_f[c] = state_reg.tr_s3[c];
            end
        end
        if (state_reg.pin_s2 == state_reg.pin_s3) begin
            state_next.pin_f = state_reg.pin_s3;
        end

        // Presence settles only after a full delay; glitches restart the count
        for (int c = 0; c < 2; c++) begin
            if (raw_present[c] == state_reg.present[c]) begin
                state_next.cnt[c] = '0;
            end else if (state_reg.cnt[c] == ecrm_pkg::CNT_W'(PRES_CYCLES - 1)) begin
                state_next.present[c] = raw_present[c];
                state_next.cnt[c] = '0;
            end else begin
                state_next.cnt[c] = state_reg.cnt[c] + 1'b1;
            end
            if (state_reg.setting[c] == ecrm_pkg::SET_AUTO) begin
                state_next.ext_out[c] = (state_reg.freq[c] >= state_reg.thresh[c])
                                        ^ state_reg.invert[c];
            end else begin
                state_next.ext_out[c] = (state_reg.setting[c] == ecrm_pkg::SET_HIGH)
                                        ^ state_reg.invert[c];
            end
            state_next.rf_out[c] = state_reg.rf_soft[c] && pin_permit
                                   && (state_reg.present[c] || carrier_ok[c]);
            state_next.car_out[c] = state_reg.rf_soft[c] && pin_permit
                                    && !state_reg.present[c] && carrier_ok[c];
        end

        // ======================================================
        // Write channel: address and data taken in either order
        if (s_axi_awvalid && state_reg.awready) begin
            state_next.aw_full = 1'b1;
            state_next.awaddr = s_axi_awaddr;
            state_next.awready = 1'b0;
        end
        if (s_axi_wvalid && state_reg.wready) begin
            state_next.w_full = 1'b1;
            state_next.wdata = s_axi_wdata;
            state_next.wstrb = s_axi_wstrb;
            state_next.wready = 1'b0;
        end
        if (state_reg.bvalid && s_axi_bready) begin
            state_next.bvalid = 1'b0;
            state_next.awready = 1'b1;
            state_next.wready = 1'b1;
        end
        if (state_reg.aw_full && state_reg.w_full && !state_reg.bvalid) begin
            pfx = state_reg.awaddr[ecrm_pkg::PREFIX_LSB +: 2];
            off = state_reg.awaddr[5:0];
            // A prefix picks channels for this access only
            mask = (pfx == 2'h0) ? state_reg.cur_chan : pfx;
            vc = (mask == 2'h2);
            ok = 1'b1;
            case (off)
                ecrm_pkg::OFF_CUR_CHAN: old_v = {30'h0, state_reg.cur_chan};
                ecrm_pkg::OFF_EXT_CTRL: old_v = {29'h0, state_reg.invert[vc],
                                                 state_reg.setting[vc]};
                ecrm_pkg::OFF_OPTIONS: old_v = {29'h0, state_reg.clock_free_mode[vc],
                                                state_reg.auto_carrier_enable[vc],
                                                state_reg.pin_pol};
                ecrm_pkg::OFF_RF_SOFT: old_v = {31'h0, state_reg.rf_soft[vc]};
                ecrm_pkg::OFF_CLK_SRC: old_v = {31'h0, state_reg.clk_src[vc]};
                default: old_v = 32'h0000_0000;
            endcase
            wd = ecrm_merge(old_v, state_reg.wdata, state_reg.wstrb);
            // Settings outside the prefix list only answer the current-channel view
            if (pfx != 2'h0 && off < ecrm_pkg::OFF_FREQ_LO) begin
                ok = 1'b0;
            end else begin
                case (off)
                    ecrm_pkg::OFF_CUR_CHAN: begin
                        if (wd[1:0] == 2'h0) begin
                            ok = 1'b0;
                        end else begin
                            state_next.cur_chan = wd[1:0];
                        end
                    end
                    ecrm_pkg::OFF_EXT_CTRL: begin
                        if (wd[ecrm_pkg::EXT_SET_LSB +: 2] > ecrm_pkg::SET_AUTO) begin
                            ok = 1'b0;
                        end else begin
                            for (int c = 0; c < 2; c++) begin
                                if (mask[c]) begin
                                    state_next.setting[c] = wd[ecrm_pkg::EXT_SET_LSB +: 2];
                                    state_next.invert[c] = wd[ecrm_pkg::EXT_INV_BIT];
                                end
                            end
                        end
                    end
                    ecrm_pkg::OFF_THRESH_LO: begin
                        state_next.thr_stage = ecrm_merge(state_reg.thr_stage,
                                                          state_reg.wdata, state_reg.wstrb);
                    end
                    ecrm_pkg::OFF_THRESH_HI: begin
                        thr_new = {state_reg.wdata[0], state_reg.thr_stage};
                        if (thr_new < ecrm_pkg::THRESH_MIN || thr_new > ecrm_pkg::THRESH_MAX) begin
                            ok = 1'b0;
                            state_next.thr_reject = 1'b1;
                        end else begin
                            state_next.thr_reject = 1'b0;
                            for (int c = 0; c < 2; c++) begin
                                if (mask[c]) begin
                                    state_next.thresh[c] = thr_new;
                                end
                            end
                        end
                    end
                    ecrm_pkg::OFF_OPTIONS: begin
                        state_next.pin_pol = wd[ecrm_pkg::OPT_PIN_POL_BIT];
                        for (int c = 0; c < 2; c++) begin
                            if (mask[c]) begin
                                state_next.auto_carrier_enable[c] = wd[ecrm_pkg::OPT_CARRIER_BIT];
                                state_next.clock_free_mode[c] = wd[ecrm_pkg::OPT_CLK_FREE_BIT];
                            end
                        end
                    end
                    ecrm_pkg::OFF_FREQ_LO: begin
                        state_next.frq_stage = ecrm_merge(state_reg.frq_stage,
                                                          state_reg.wdata, state_reg.wstrb);
                    end
                    ecrm_pkg::OFF_FREQ_HI, ecrm_pkg::OFF_RF_SOFT, ecrm_pkg::OFF_CLK_SRC: begin
                        for (int c = 0; c < 2; c++) begin
                            if (mask[c]) begin
                                if (off == ecrm_pkg::OFF_FREQ_HI) begin
                                    state_next.freq[c] = {state_reg.wdata[0], state_reg.frq_stage};
                                end else if (off == ecrm_pkg::OFF_RF_SOFT) begin
                                    state_next.rf_soft[c] = wd[0];
                                end else begin
                                    state_next.clk_src[c] = wd[0];
                                end
                            end
                        end
                    end
                    default: ok = 1'b0;
                endcase
            end
            state_next.aw_full = 1'b0;
            state_next.w_full = 1'b0;
            state_next.bvalid = 1'b1;
            state_next.bresp = ok ? ecrm_pkg::RESP_OKAY : ecrm_pkg::RESP_SLVERR;
        end

        // ======================================================
        // Read channel: data registered on the address handshake
        if (state_reg.rvalid && s_axi_rready) begin
            state_next.rvalid = 1'b0;
            state_next.arready = 1'b1;
        end
        if (s_axi_arvalid && state_reg.arready) begin
            rpfx = s_axi_araddr[ecrm_pkg::PREFIX_LSB +: 2];
            roff = s_axi_araddr[5:0];
            rvc = (((rpfx == 2'h0) ? state_reg.cur_chan : rpfx) == 2'h2);
            rok = !(rpfx != 2'h0 && roff < ecrm_pkg::OFF_FREQ_LO);
            case (roff)
                ecrm_pkg::OFF_CUR_CHAN: rd = {30'h0, state_reg.cur_chan};
                ecrm_pkg::OFF_EXT_CTRL: rd = {29'h0, state_reg.invert[rvc],
                                              state_reg.setting[rvc]};
                ecrm_pkg::OFF_THRESH_LO: rd = state_reg.thresh[rvc][31:0];
                ecrm_pkg::OFF_THRESH_HI: rd = {31'h0, state_reg.thresh[rvc][32]};
                ecrm_pkg::OFF_OPTIONS: rd = {29'h0, state_reg.clock_free_mode[rvc],
                                             state_reg.auto_carrier_enable[rvc],
                                             state_reg.pin_pol};
                ecrm_pkg::OFF_STATUS: rd = {23'h0, state_reg.thr_reject, state_reg.present,
                                            state_reg.ext_out, state_reg.car_out,
                                            state_reg.rf_out};
                ecrm_pkg::OFF_FREQ_LO: rd = state_reg.freq[rvc][31:0];
                ecrm_pkg::OFF_FREQ_HI: rd = {31'h0, state_reg.freq[rvc][32]};
                ecrm_pkg::OFF_RF_SOFT: rd = {31'h0, state_reg.rf_soft[rvc]};
                ecrm_pkg::OFF_CLK_SRC: rd = {31'h0, state_reg.clk_src[rvc]};
                default: rok = 1'b0;
            endcase
            state_next.arready = 1'b0;
            state_next.rvalid = 1'b1;
            state_next.rdata = rok ? rd : 32'h0000_0000;
            state_next.rresp = rok ? ecrm_pkg::RESP_OKAY : ecrm_pkg::RESP_SLVERR;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= '0;
            state_reg.awready <= 1'b1;
            state_reg.wready <= 1'b1;
            state_reg.arready <= 1'b1;
            state_reg.cur_chan <= ecrm_pkg::RST_CUR_CHAN;
            state_reg.setting <= {2{ecrm_pkg::RST_SETTING}};
            state_reg.thresh <= {2{ecrm_pkg::RST_THRESH}};
            state_reg.freq <= {2{ecrm_pkg::RST_FREQ}};
            state_reg.rf_soft <= {2{ecrm_pkg::RST_RF_SOFT}};
            state_reg.pin_pol <= ecrm_pkg::RST_PIN_POL;
        end else begin
            state_reg <= state_next;
        end
    end

    assign s_axi_awready = state_reg.awready;
    assign s_axi_wready = state_reg.wready;
    assign s_axi_bvalid = state_reg.bvalid;
    assign s_axi_bresp = state_reg.bresp;
    assign s_axi_arready = state_reg.arready;
    assign s_axi_rvalid = state_reg.rvalid;
    assign s_axi_rdata = state_reg.rdata;
    assign s_axi_rresp = state_reg.rresp;
    assign ext_ctrl_out = state_reg.ext_out;
    assign rf_enable_out = state_reg.rf_out;
    assign carrier_only_out = state_reg.car_out;

    // ==========================================================
    // Checks
    default clocking ast_cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_wcommit;
        state_reg.aw_full && state_reg.w_full && !state_reg.bvalid;
    endsequence
    sequence s_prefixed;
        state_reg.awaddr[ecrm_pkg::PREFIX_LSB +: 2] != 2'h0;
    endsequence

    AST_FORCED_LOW: assert property (state_reg.setting[0] == ecrm_pkg::SET_LOW |=>
        ext_ctrl_out[0] == $past(state_reg.invert[0])) else $error("forced low level wrong");
    AST_FORCED_HIGH: assert property (state_reg.setting[1] == ecrm_pkg::SET_HIGH |=>
        ext_ctrl_out[1] == !$past(state_reg.invert[1])) else $error("forced high level wrong");
    AST_AUTO_CMP: assert property (state_reg.setting[0] == ecrm_pkg::SET_AUTO |=>
        ext_ctrl_out[0] == ($past(state_reg.freq[0] >= state_reg.thresh[0])
        ^ $past(state_reg.invert[0]))) else $error("automatic compare wrong");
    AST_THR_IGNORED: assert property (state_reg.setting[0] != ecrm_pkg::SET_AUTO
        && $stable(state_reg.setting[0]) && $stable(state_reg.invert[0]) ##1 $stable(state_reg.setting[0])
        && $stable(state_reg.invert[0]) |=> $stable(ext_ctrl_out[0]))
        else $error("threshold moved forced output");
    AST_THR_RANGE: assert property (state_reg.thresh[0] >= ecrm_pkg::THRESH_MIN
        && state_reg.thresh[0] <= ecrm_pkg::THRESH_MAX) else $error("threshold out of range");
    AST_PREFIX_KEEPS: assert property (s_wcommit ##0 s_prefixed |=>
        $stable(state_reg.cur_chan) && state_reg.bvalid) else $error("prefix changed channel");
    AST_RF_AND: assert property (##1 rf_enable_out[0] == $past(state_reg.rf_soft[0]
        && pin_permit && (state_reg.present[0] || carrier_ok[0]))) else $error("rf enable wrong");
    AST_PIN_VETO: assert property (!pin_permit [*2] |-> !rf_enable_out[0] &&
        !rf_enable_out[1]) else $error("pin veto ignored");
    AST_SETTLE: assert property ($changed(state_reg.present[0]) |->
        $past(state_reg.cnt[0]) == ecrm_pkg::CNT_W'(PRES_CYCLES - 1)) else $error("early presence");
    AST_CARRIER: assert property (carrier_only_out[1] |->
        $past(!state_reg.present[1] && carrier_ok[1])) else $error("carrier without loss");
endmodule
